// file: icdec_pkg.sv
package icdec_pkg;

	// ------------------------------------------------------------
	// message and sizing constants
	// ------------------------------------------------------------
	localparam int MSG_MAX   = 32;            // longest command, NUL excluded
	localparam int NIF_DEF   = 8;             // board interfaces / ports
	localparam int NCHAN_DEF = 64;            // addressable channels
	localparam int DN_MAX    = 15;            // subscriber number digits

	// ------------------------------------------------------------
	// register port map (word index on the plain port)
	// ------------------------------------------------------------
	localparam logic [3:0] A_CMD_DATA = 4'h0; // w: next command character, 00h ends it
	localparam logic [3:0] A_STATUS   = 4'h1; // r: comms, reply pending, store valid, overrun
	localparam logic [3:0] A_REPLY    = 4'h2; // r: reply code and error, read clears pending
	localparam logic [3:0] A_CLOCK    = 4'h3; // r: clock mode, submode, extra fields
	localparam logic [3:0] A_BUS      = 4'h4; // r: stream rates, companding, termination
	localparam logic [3:0] A_BASE_TS  = 4'h5; // r: base stream and timeslot
	localparam logic [3:0] A_LAYER3   = 4'h6; // r: layer 3 options and port levels
	localparam logic [3:0] A_SPAN     = 4'h7; // r: span type per interface
	localparam logic [3:0] A_SEL      = 4'h8; // rw: index for the table readbacks
	localparam logic [3:0] A_FRAME    = 4'h9; // r: framing of the selected interface
	localparam logic [3:0] A_LINE     = 4'ha; // r: line protocol of the selected channel
	localparam logic [3:0] A_DN       = 4'hb; // r: length and low digits of the number

	// ------------------------------------------------------------
	// field encodings and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] RATE_2M   = 2'h0;
	localparam logic [1:0] RATE_8M   = 2'h2;  // reset value of every stream group
	localparam logic [3:0] CLK_MODE_DEF = 4'h0;
	localparam logic [1:0] SPAN_NT   = 2'h0;
	localparam logic [1:0] SPAN_TE   = 2'h1;
	localparam logic [1:0] SPAN_UNUSED = 2'h2; // reset value
	localparam logic [1:0] SIG_NONE  = 2'h0;
	localparam logic [1:0] SIG_CAS   = 2'h1;
	localparam logic [1:0] SIG_PRI   = 2'h2;
	localparam logic [1:0] SIG_SS7   = 2'h3;
	localparam logic [7:0] L3OPT_DEF = 8'h00; // every option no

	typedef enum logic [2:0] {LT_NONE, LT_EM, LT_GROUND, LT_LOOP, LT_Q421, LT_DIRECT} icdec_ltype_e;

	typedef struct packed {
		logic       crc4;
		logic       hdb3;
		logic [1:0] sig;
		logic       imp75;
		logic       v52;
	} icdec_frame_s;

	typedef struct packed {
		icdec_ltype_e ltype;
		logic         office;
		logic         wink;
		logic [3:0]   ndig;
	} icdec_line_s;

	typedef struct packed {
		logic [3:0]  len;
		logic [59:0] digits;                  // digit 0 in the low nibble
	} icdec_dn_s;

	typedef struct packed {
		logic [15:0] code;
		logic        err;
	} icdec_reply_s;

endpackage : icdec_pkg

// file: icdec_core.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Function
// - nothing but enable is accepted until enabled; enable answers with ack code.
// - reset command restarts the block and echoes its own code.
// - clock mode command stores mode, submode, first three extras; restart gives mode 0.
// - four rate digits cover stream groups 0-3, 4-7, 8-11, 12-15.
// - rate digit 0, 1, 2 means 2, 4, 8 MHz; default 8 MHz.
// - companding M is Mu-Law, A is A-Law; A-Law after restart.
// - framing command: two-digit interface, C or N framing, A or H coding.
// - framing signaling character N, C, P or S.
// - impedance R or B, optional trailing V for V5.2.
// - line protocol: two-digit channel, type EGLQXN, direction S or O.
// - E&M may add I or W start and an address digit count.
// - span command has one N, T, U or * per interface; * keeps.
// - termination command: main then legacy bus, E enables, D disables.
// - base timeslot is one hex stream digit and two hex timeslot digits.
// - protocol level digit per port, 2 or 3; Layer 3 default.
// - subscriber number per two-digit channel, up to 15 digits.
// - eight Y/N layer 3 options, all N by default, e-h reserved.
// - options a-d steer connect ack, calling number, NSAP format, timers.
// - save copies spans, framing, levels and numbers into the store.
// - load copies the store back; restart loads when the store is valid.
// - clear empties the store, so restart keeps the defaults.
// - commands are at most 32 characters, ended by NUL.
// - mailbox flag handshake is the transport's job outside this block.
module icdec_core
	import icdec_pkg::*;
#(
	parameter int NIF   = NIF_DEF,
	parameter int NCHAN = NCHAN_DEF
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// register port
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata_ff,
	// settings that steer the rest of the board
	output logic             comms_en_ff,
	output logic [3:0]       clk_mode_ff,
	output logic [7:0]       rate_ff,
	output logic             alaw_ff,
	output logic             term_main_ff,
	output logic             term_legacy_ff,
	output logic [7:0]       l3opt_ff
);

	// ------------------------------------------------------------
	// types, state and storage
	// ------------------------------------------------------------
	typedef enum logic [1:0] {S_COLLECT, S_EXEC, S_LOAD} icdec_state_e;
	typedef enum logic [4:0] {K_NONE, K_IN, K_RESET, K_CLOCK, K_RATE, K_COMPAND, K_FRAME,
		K_LINE, K_SPAN, K_TERM, K_BASE, K_LEVEL, K_NUMBER, K_SS, K_SAVE, K_LOAD,
		K_CLEAR} icdec_kind_e;

	icdec_state_e  st_ff;
	logic [7:0]    buf_ff [MSG_MAX];
	logic [5:0]    len_ff;
	logic          toolong_ff, overrun_ff, pend_ff, nv_valid_ff;
	icdec_reply_s  reply_ff;
	logic [3:0]    submode_ff;
	logic [23:0]   clk_ext_ff;
	logic [11:0]   base_ts_ff;
	logic [7:0]    sel_ff;
	logic [1:0]    span_ff [NIF];
	logic          lvl3_ff [NIF];
	icdec_frame_s  frm_ff [NIF];
	icdec_line_s   line_ff [NCHAN];
	icdec_dn_s     dn_ff [NCHAN];
	// nonvolatile shadow, deliberately outside the reset
	logic [1:0]    nv_span_ff [NIF];
	logic          nv_lvl3_ff [NIF];
	icdec_frame_s  nv_frm_ff [NIF];
	icdec_dn_s     nv_dn_ff [NCHAN];

	function automatic logic is_dig(input logic [7:0] c);
		return c >= "0" && c <= "9";
	endfunction : is_dig

	function automatic logic [3:0] dig(input logic [7:0] c);
		return 4'(c - "0");
	endfunction : dig

	function automatic logic is_hex(input logic [7:0] c);
		return is_dig(c) || (c >= "A" && c <= "F");
	endfunction : is_hex

	function automatic logic [3:0] hexv(input logic [7:0] c);
		return is_dig(c) ? dig(c) : 4'(c - "A" + 8'h0a);
	endfunction : hexv

	// ------------------------------------------------------------
	// command decode, evaluated on the buffered message
	// ------------------------------------------------------------
	icdec_kind_e kind;
	logic        ok;
	logic [7:0]  idx;
	logic        exec, do_rst, do_load;

	// every check is done before anything is written
	always_comb begin
		kind = K_NONE;
		ok   = 1'b0;
		idx  = 8'(dig(buf_ff[2])) * 8'd10 + 8'(dig(buf_ff[3])); // widen first, a 4-bit product wraps
		unique case ({buf_ff[0], buf_ff[1]})
			"IN": begin
				kind = K_IN;
				ok   = len_ff == 6'd2;
			end
			16'h5241: begin                                // restart
				kind = K_RESET;
				ok   = len_ff == 6'd2;
			end
			16'h5343: begin
				kind = K_CLOCK;
				ok   = len_ff >= 6'd4 && len_ff <= 6'd8 && is_dig(buf_ff[2]) && is_dig(buf_ff[3]);
			end
			16'h5342: begin
				kind = K_RATE;
				ok   = len_ff == 6'd6;
				for (int i = 2; i < 6; i++)
					if (buf_ff[i] < "0" || buf_ff[i] > "2") ok = 1'b0;
			end
			16'h5345: begin
				kind = K_COMPAND;
				ok   = len_ff == 6'd3 && (buf_ff[2] == "M" || buf_ff[2] == "A");
			end
			16'h5346: begin                                // framing
				kind = K_FRAME;
				ok   = (len_ff == 6'd8 || (len_ff == 6'd9 && buf_ff[8] == "V"))
					&& is_dig(buf_ff[2]) && is_dig(buf_ff[3]) && idx < 8'(NIF)
					&& (buf_ff[4] == "C" || buf_ff[4] == "N")
					&& (buf_ff[5] == "A" || buf_ff[5] == "H")
					&& (buf_ff[6] inside {"N", "C", "P", "S"})
					&& (buf_ff[7] == "R" || buf_ff[7] == "B");
			end
			16'h5350: begin                                // line protocol
				kind = K_LINE;
				ok   = is_dig(buf_ff[2]) && is_dig(buf_ff[3]) && idx < 8'(NCHAN)
					&& (buf_ff[4] inside {"E", "G", "L", "Q", "X", "N"})
					&& (buf_ff[5] == "S" || buf_ff[5] == "O")
					&& (len_ff == 6'd6 || (len_ff == 6'd8 && buf_ff[4] == "E"
						&& (buf_ff[6] == "I" || buf_ff[6] == "W") && is_dig(buf_ff[7])));
			end
			16'h5354: begin                                // span or termination
				if (len_ff == 6'd4) begin
					kind = K_TERM;
					ok   = (buf_ff[2] == "E" || buf_ff[2] == "D")
						&& (buf_ff[3] == "E" || buf_ff[3] == "D");
				end else begin
					kind = K_SPAN;
					ok   = len_ff == 6'(NIF + 2);
					for (int i = 0; i < NIF; i++)
						if (!(buf_ff[i+2] inside {"N", "T", "U", "*"})) ok = 1'b0;
				end
			end
			16'h5358: begin
				kind = K_BASE;
				ok   = len_ff == 6'd5 && is_hex(buf_ff[2]) && is_hex(buf_ff[3]) && is_hex(buf_ff[4]);
			end
			16'h534c: begin
				kind = K_LEVEL;
				ok   = len_ff == 6'(NIF + 2);
				for (int i = 0; i < NIF; i++)
					if (buf_ff[i+2] != "2" && buf_ff[i+2] != "3") ok = 1'b0;
			end
			16'h5344: begin
				kind = K_NUMBER;
				ok   = len_ff >= 6'd4 && len_ff <= 6'(DN_MAX + 4) && is_dig(buf_ff[2])
					&& is_dig(buf_ff[3]) && idx < 8'(NCHAN);
				for (int i = 4; i < MSG_MAX; i++)
					if (6'(i) < len_ff && !is_dig(buf_ff[i])) ok = 1'b0;
			end
			"SS": begin
				kind = K_SS;
				ok   = len_ff == 6'd10;
				for (int i = 2; i < 10; i++)
					if (buf_ff[i] != "Y" && buf_ff[i] != "N") ok = 1'b0;
			end
			"SM": begin
				kind = buf_ff[2] == "S" ? K_SAVE : buf_ff[2] == "L" ? K_LOAD
					: buf_ff[2] == "C" ? K_CLEAR : K_NONE;
				ok   = len_ff == 6'd3 && kind != K_NONE;
			end
			default: begin
			end
		endcase
		// nothing but enable passes while messaging is off
		if (toolong_ff || (!comms_en_ff && kind != K_IN))
			ok = 1'b0;
	end

	assign exec    = st_ff == S_EXEC && ok;
	assign do_rst  = exec && kind == K_RESET;
	assign do_load = nv_valid_ff && ((exec && kind == K_LOAD) || st_ff == S_LOAD);

	// ------------------------------------------------------------
	// message collection and sequencing
	// ------------------------------------------------------------
	// characters that land during execution are dropped and flagged
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_ff      <= S_LOAD;
			len_ff     <= 6'd0;
			toolong_ff <= 1'b0;
		end else begin
			unique case (st_ff)
				S_COLLECT: if (wr && addr == A_CMD_DATA) begin
					if (wdata[7:0] == 8'h00) begin
						st_ff <= S_EXEC;
					end else if (len_ff < 6'(MSG_MAX)) begin
						buf_ff[len_ff[4:0]] <= wdata[7:0];
						len_ff              <= len_ff + 6'd1;
					end else begin
						toolong_ff <= 1'b1;
					end
				end
				S_EXEC: begin
					st_ff      <= do_rst ? S_LOAD : S_COLLECT;
					len_ff     <= 6'd0;
					toolong_ff <= 1'b0;
				end
				S_LOAD: st_ff <= S_COLLECT;
			endcase
		end
	end

	// reply and sticky status; a new event beats a clearing read
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pend_ff    <= 1'b0;
			overrun_ff <= 1'b0;
			reply_ff   <= '0;
		end else begin
			if (st_ff == S_EXEC) begin
				pend_ff       <= 1'b1;                   // reader frees it
				reply_ff.code <= kind == K_IN ? 16'h4941 : {buf_ff[0], buf_ff[1]};
				reply_ff.err  <= !ok;
			end else if (rd && addr == A_REPLY) begin
				pend_ff <= 1'b0;
			end
			if (wr && addr == A_CMD_DATA && st_ff != S_COLLECT)
				overrun_ff <= 1'b1;
			else if (rd && addr == A_STATUS)
				overrun_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// settings that are never restored from the store
	// ------------------------------------------------------------
	// enable and clock mode must be resent after a restart
	always_ff @(posedge mclk) begin
		if (!rstn || do_rst) begin
			comms_en_ff <= 1'b0;
			clk_mode_ff <= CLK_MODE_DEF;
			submode_ff  <= 4'h0;
			clk_ext_ff  <= 24'h0;
		end else if (exec && kind == K_IN) begin
			comms_en_ff <= 1'b1;
		end else if (exec && kind == K_CLOCK) begin
			clk_mode_ff <= dig(buf_ff[2]);
			submode_ff  <= dig(buf_ff[3]);
			// absent fields read as zero, never as a leftover of an older command
			clk_ext_ff  <= {len_ff > 6'd4 ? buf_ff[4] : 8'h00, len_ff > 6'd5 ? buf_ff[5] : 8'h00,
				len_ff > 6'd6 ? buf_ff[6] : 8'h00};
		end
	end

	// bus wide settings
	always_ff @(posedge mclk) begin
		if (!rstn || do_rst) begin
			rate_ff        <= {4{RATE_8M}};
			alaw_ff        <= 1'b1;
			term_main_ff   <= 1'b0;
			term_legacy_ff <= 1'b0;
			base_ts_ff     <= 12'h0;
			l3opt_ff       <= L3OPT_DEF;
		end else if (exec) begin
			if (kind == K_RATE)
				for (int g = 0; g < 4; g++)                  // group g lands in bits 2g+1:2g
					rate_ff[2*g +: 2] <= 2'(buf_ff[g+2] - "0");
			if (kind == K_COMPAND)
				alaw_ff <= buf_ff[2] == "A";
			if (kind == K_TERM) begin
				term_main_ff   <= buf_ff[2] == "E";
				term_legacy_ff <= buf_ff[3] == "E";
			end
			if (kind == K_BASE)
				base_ts_ff <= {hexv(buf_ff[2]), hexv(buf_ff[3]), hexv(buf_ff[4])};
			if (kind == K_SS)
				for (int o = 0; o < 8; o++)                  // bit 0 is option a
					l3opt_ff[o] <= buf_ff[o+2] == "Y";
		end
	end

	// ------------------------------------------------------------
	// per interface and per channel tables
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn || do_rst) begin
			for (int i = 0; i < NIF; i++) begin
				span_ff[i] <= SPAN_UNUSED;
				lvl3_ff[i] <= 1'b1;
				frm_ff[i]  <= '0;
			end
		end else if (do_load) begin
			for (int i = 0; i < NIF; i++) begin
				span_ff[i] <= nv_span_ff[i];
				lvl3_ff[i] <= nv_lvl3_ff[i];
				frm_ff[i]  <= nv_frm_ff[i];
			end
		end else if (exec && kind == K_SPAN) begin
			for (int i = 0; i < NIF; i++)
				if (buf_ff[i+2] != "*")
					span_ff[i] <= buf_ff[i+2] == "N" ? SPAN_NT
						: buf_ff[i+2] == "T" ? SPAN_TE : SPAN_UNUSED;
		end else if (exec && kind == K_LEVEL) begin
			for (int i = 0; i < NIF; i++)
				lvl3_ff[i] <= buf_ff[i+2] == "3";
		end else if (exec && kind == K_FRAME) begin
			frm_ff[idx[2:0]].crc4  <= buf_ff[4] == "C";
			frm_ff[idx[2:0]].hdb3  <= buf_ff[5] == "H";
			frm_ff[idx[2:0]].sig   <= buf_ff[6] == "C" ? SIG_CAS : buf_ff[6] == "P" ? SIG_PRI
				: buf_ff[6] == "S" ? SIG_SS7 : SIG_NONE;
			frm_ff[idx[2:0]].imp75 <= buf_ff[7] == "B";
			frm_ff[idx[2:0]].v52   <= len_ff == 6'd9;
		end
	end

	// channel tables; numbers survive a restart only through the store
	always_ff @(posedge mclk) begin
		if (!rstn || do_rst) begin
			for (int c = 0; c < NCHAN; c++) begin
				line_ff[c] <= '0;
				dn_ff[c]   <= '0;
			end
		end else if (do_load) begin
			for (int c = 0; c < NCHAN; c++)
				dn_ff[c] <= nv_dn_ff[c];
		end else if (exec && kind == K_LINE) begin
			line_ff[idx[5:0]].ltype  <= buf_ff[4] == "E" ? LT_EM : buf_ff[4] == "G" ? LT_GROUND
				: buf_ff[4] == "L" ? LT_LOOP : buf_ff[4] == "Q" ? LT_Q421
				: buf_ff[4] == "X" ? LT_DIRECT : LT_NONE;
			line_ff[idx[5:0]].office <= buf_ff[5] == "O";
			line_ff[idx[5:0]].wink   <= len_ff == 6'd8 && buf_ff[6] == "W";
			line_ff[idx[5:0]].ndig   <= len_ff == 6'd8 ? dig(buf_ff[7]) : 4'h0;
		end else if (exec && kind == K_NUMBER) begin
			dn_ff[idx[5:0]].len <= 4'(len_ff - 6'd4);
			for (int d = 0; d < DN_MAX; d++)
				dn_ff[idx[5:0]].digits[4*d +: 4] <= 6'(d + 4) < len_ff ? dig(buf_ff[d+4]) : 4'h0;
		end
	end

	// ------------------------------------------------------------
	// nonvolatile store model
	// ------------------------------------------------------------
	// contents are not reset; only the valid mark is, as an empty store
	always_ff @(posedge mclk) begin
		if (exec && kind == K_SAVE) begin
			for (int i = 0; i < NIF; i++) begin
				nv_span_ff[i] <= span_ff[i];
				nv_lvl3_ff[i] <= lvl3_ff[i];
				nv_frm_ff[i]  <= frm_ff[i];
			end
			for (int c = 0; c < NCHAN; c++)
				nv_dn_ff[c] <= dn_ff[c];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn)
			nv_valid_ff <= 1'b0;
		else if (exec && kind == K_SAVE)
			nv_valid_ff <= 1'b1;
		else if (exec && kind == K_CLEAR)
			nv_valid_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn)
			sel_ff <= 8'h0;
		else if (wr && addr == A_SEL)
			sel_ff <= wdata[7:0];
	end

	// read data stand in the cycle after the strobe only
	always_ff @(posedge mclk) begin
		if (!rstn || !rd) begin
			rdata_ff <= 32'h0;
		end else begin
			rdata_ff <= 32'h0;
			unique case (addr)
				A_STATUS:  rdata_ff[9:0] <= {len_ff, overrun_ff, nv_valid_ff, pend_ff, comms_en_ff};
				A_REPLY:   rdata_ff[16:0] <= reply_ff;
				A_CLOCK:   rdata_ff <= {clk_ext_ff, submode_ff, clk_mode_ff};
				A_BUS:     rdata_ff[10:0] <= {term_legacy_ff, term_main_ff, alaw_ff, rate_ff};
				A_BASE_TS: rdata_ff[11:0] <= base_ts_ff;
				A_LAYER3:  begin
					rdata_ff[7:0] <= l3opt_ff;
					for (int i = 0; i < NIF; i++)
						rdata_ff[8+i] <= lvl3_ff[i];
				end
				A_SPAN:    for (int i = 0; i < NIF; i++)
					rdata_ff[2*i +: 2] <= span_ff[i];
				A_SEL:     rdata_ff[7:0] <= sel_ff;
				A_FRAME:   rdata_ff[5:0] <= frm_ff[sel_ff[2:0]];
				A_LINE:    rdata_ff[8:0] <= line_ff[sel_ff[5:0]];
				A_DN:      rdata_ff <= {dn_ff[sel_ff[5:0]].len, dn_ff[sel_ff[5:0]].digits[27:0]};
				default:   rdata_ff <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_enable_ack;
		exec && kind == K_IN |=> comms_en_ff && pend_ff && reply_ff.code == 16'h4941
			&& !reply_ff.err;
	endproperty
	a_enable_ack: assert property (p_enable_ack) else $error("enable not acknowledged");

	property p_locked;
		st_ff == S_EXEC && !comms_en_ff && kind == K_COMPAND |=> $stable(alaw_ff) && reply_ff.err;
	endproperty
	a_locked: assert property (p_locked) else $error("command taken while disabled");

	property p_reset_echo;
		do_rst |=> reply_ff.code == 16'h5241 && !comms_en_ff ##1 st_ff == S_COLLECT;
	endproperty
	a_reset_echo: assert property (p_reset_echo) else $error("reset echo wrong");

	property p_clk_default;
		do_rst |=> clk_mode_ff == CLK_MODE_DEF && submode_ff == 4'h0;
	endproperty
	a_clk_default: assert property (p_clk_default) else $error("clock mode not 0");

	property p_rate_default;
		do_rst |=> rate_ff == {4{RATE_8M}} && alaw_ff;
	endproperty
	a_rate_default: assert property (p_rate_default) else $error("bus defaults wrong");

	property p_l3_default;
		do_rst |=> l3opt_ff == L3OPT_DEF;
	endproperty
	a_l3_default: assert property (p_l3_default) else $error("options not all no");

	property p_reject;
		st_ff == S_EXEC && !ok |=> $stable(rate_ff) && $stable(alaw_ff) && $stable(l3opt_ff)
			&& $stable(base_ts_ff) && $stable(nv_valid_ff);
	endproperty
	a_reject: assert property (p_reject) else $error("rejected command changed state");

	property p_clear;
		exec && kind == K_CLEAR |=> !nv_valid_ff ##1 !do_load;
	endproperty
	a_clear: assert property (p_clear) else $error("store still valid");

	c_enable:  cover property (exec && kind == K_IN);
	c_restore: cover property (do_rst ##1 st_ff == S_LOAD && nv_valid_ff);
	c_reject:  cover property (st_ff == S_EXEC && comms_en_ff && !ok);

endmodule : icdec_core

// file: icdec_host.sv
`timescale 1ns/1ps
// host model: drives the command port one character per write cycle
module icdec_host
	import icdec_pkg::*;
(
	// clock
	input  wire logic        mclk,
	// register port
	output logic      [3:0]  addr,
	output logic      [31:0] wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [31:0] rdata_ff
);
	// idle bus at time zero
	initial begin
		addr  = 4'h0;
		wdata = 32'h0;
		wr    = 1'b0;
		rd    = 1'b0;
	end
	// one write; data is inverted after release so a stale value never looks valid
	task automatic put(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask : put
	// one read; data taken in the only cycle it stands
	task automatic get(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1 d = rdata_ff;
	endtask : get
	// whole command with NUL, then room for execution and a possible restart
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) put(A_CMD_DATA, {24'h0, s[i]});
		put(A_CMD_DATA, 32'h0);
		repeat (6) @(posedge mclk);
	endtask : send
endmodule : icdec_host

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	import icdec_pkg::*;
	logic        mclk, rstn, wr, rd, comms_en_ff, alaw_ff, term_main_ff, term_legacy_ff;
	logic [3:0]  addr, clk_mode_ff;
	logic [31:0] wdata, rdata_ff;
	logic [7:0]  rate_ff, l3opt_ff;
	int          err_total, tests_run;
	// ------------------------------------------------------------
	// clock, design and host
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	icdec_core dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_ff(rdata_ff), .comms_en_ff(comms_en_ff), .clk_mode_ff(clk_mode_ff),
		.rate_ff(rate_ff), .alaw_ff(alaw_ff), .term_main_ff(term_main_ff),
		.term_legacy_ff(term_legacy_ff), .l3opt_ff(l3opt_ff));
	icdec_host host_u (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_ff(rdata_ff));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// read a register and compare the masked field
	task automatic reg_is(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		host_u.get(a, d);
		chk(d & m, e);
	endtask : reg_is
	// reply code and error flag of the last command
	task automatic reply(input logic [15:0] code, input logic err);
		reg_is(A_REPLY, 32'h1ffff, {15'h0, code, err});
	endtask : reply
	task automatic wrap_up;
		if (err_total == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_defaults;
		chk({28'h0, clk_mode_ff}, 32'h0);
		chk({24'h0, rate_ff}, 32'haa);
		chk({31'h0, alaw_ff}, 32'h1);
		chk({24'h0, l3opt_ff}, 32'h0);
		reg_is(A_LAYER3, 32'hffff, 32'hff00);
		chk({31'h0, comms_en_ff}, 32'h0);
	endtask : t_defaults
	// commands before enable are refused; enable answers with ack code
	task automatic t_enable;
		host_u.send("SEM");
		chk({31'h0, alaw_ff}, 32'h1);
		reply(16'h5345, 1'b1);
		host_u.send("IN");
		chk({31'h0, comms_en_ff}, 32'h1);
		reg_is(A_STATUS, 32'h3, 32'h3);
		reply(16'h4941, 1'b0);
		reg_is(A_STATUS, 32'h2, 32'h0);
	endtask : t_enable
	task automatic t_bus;
		host_u.send("SEM");
		chk({31'h0, alaw_ff}, 32'h0);
		host_u.send("SEX");
		chk({31'h0, alaw_ff}, 32'h0);
		reply(16'h5345, 1'b1);
		host_u.send("SEA");
		chk({31'h0, alaw_ff}, 32'h1);
		host_u.send("SB0120");
		chk({24'h0, rate_ff}, 32'h24);
		host_u.send("SB2103");
		chk({24'h0, rate_ff}, 32'h24);
		host_u.send("SB2210");
		chk({24'h0, rate_ff}, 32'h1a);
		host_u.send("STED");
		chk({30'h0, term_main_ff, term_legacy_ff}, 32'h2);
		host_u.send("STDE");
		chk({30'h0, term_main_ff, term_legacy_ff}, 32'h1);
		host_u.send("SSYNYNNNNY");
		chk({24'h0, l3opt_ff}, 32'h85);
		host_u.send("SSNYNYNNNN");
		chk({24'h0, l3opt_ff}, 32'h0a);
	endtask : t_bus
	// framing, line protocol, numbers, base timeslot and levels through the readbacks
	task automatic t_tables;
		host_u.send("SF03CHPBV");
		host_u.send("SF09CHPB");
		reply(16'h5346, 1'b1);
		host_u.put(A_SEL, 32'h1);
		reg_is(A_FRAME, 32'h3f, 32'h0);
		host_u.put(A_SEL, 32'h3);
		reg_is(A_FRAME, 32'h3f, 32'h3b);
		host_u.send("SP42EOW5");
		host_u.send("SD425551234");
		host_u.put(A_SEL, 32'h2a);
		reg_is(A_SEL, 32'hff, 32'h2a);
		reg_is(A_LINE, 32'h1ff, 32'h75);
		reg_is(A_DN, 32'hffffffff, 32'h74321555);
		host_u.send("SX1A3");
		reg_is(A_BASE_TS, 32'hfff, 32'h1a3);
		host_u.send("SL23333332");
		reg_is(A_LAYER3, 32'hff00, 32'h7e00);
	endtask : t_tables
	// clock mode set, then a restart drops it and messaging
	task automatic t_restart;
		host_u.send("SC3100");
		chk({28'h0, clk_mode_ff}, 32'h3);
		reg_is(A_CLOCK, 32'hffffffff, 32'h30300013);
		host_u.send(string'(16'h5241));
		reply(16'h5241, 1'b0);
		chk({27'h0, comms_en_ff, clk_mode_ff}, 32'h0);
		host_u.send("IN");
		host_u.send("SC00");
	endtask : t_restart
	// save, modify, load, restart with and without a stored set
	task automatic t_store;
		host_u.send("STNTUUUUUU");
		reg_is(A_SPAN, 32'hffff, 32'haaa4);
		host_u.send(string'(24'h534d53));
		reg_is(A_STATUS, 32'h4, 32'h4);
		host_u.send("STT*******");
		reg_is(A_SPAN, 32'hffff, 32'haaa5);
		host_u.send(string'(24'h534d4c));
		reg_is(A_SPAN, 32'hffff, 32'haaa4);
		host_u.send("STT*******");
		host_u.send(string'(16'h5241));
		host_u.send("IN");
		host_u.send("SC00");
		reg_is(A_SPAN, 32'hffff, 32'haaa4);
		host_u.send(string'(24'h534d43));
		reg_is(A_STATUS, 32'h4, 32'h0);
		host_u.send(string'(16'h5241));
		host_u.send("IN");
		host_u.send("SC00");
		reg_is(A_SPAN, 32'hffff, 32'haaaa);
	endtask : t_store
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		err_total = 0;
		tests_run = 0;
		rstn      = 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		t_defaults;
		t_enable;
		t_bus;
		t_tables;
		t_restart;
		t_store;
		wrap_up;
	end
endmodule : testbench
